// ---- rtl/timer16_capture.sv ----
// Functional notes
// [R1] 16-bit up-counter, prescaler 2/4/8 or external
// [R2] reset and low-byte writes reload FFFCh
// [R3] internal period 131072/262144/524288 cycles
// [R4] external clock only when both bits set
// [R5] edge select for external clock, synchronous
// [R6] external edges at least four cycles apart
// [R7] alternate view never clears overflow flag
// [R8] high-byte read freezes low byte copy
// [R9] software reads high byte before low
// [R10] overflow flag set on FFFF to 0000
// [R11] overflow irq while flag, enable, mask clear
// [R12] overflow clears by status read then low access
// [R13] runs in wait, stops in halt
// [R14] capture edge copies counter, sets flag
// [R15] per-channel capture edge select bit
// [R16] shared capture irq enable for both channels
// [R17] capture flag clears by status then low access
// [R18] high read blocks capture until low read
// [R19] opm/pwm leaves only channel two capture; code also drops channel one with /8 or external clock (CR2_PWM is clock bit 3)
// [R20] capture pins always feed capture logic
// [R21] unbonded timer input reads as one
// [R22] flash variant removes capture channel two
// [R23] byte registers, side effects on access cycle
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module timer16_capture #(
  parameter bit CH2_PRESENT = 1'b1,
  parameter bit EXT_BONDED = 1'b1,
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic HALT,
  input wire logic CPU_IRQ_MASK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_CLOCK_PIN,
  input wire logic CAPTURE_PIN_ONE,
  input wire logic CAPTURE_PIN_TWO,
  output logic OVF_IRQ,
  output logic CAP_IRQ
);
  import timer16_pkg::*;

  // ==========================================================
  // bus decode
  logic [7:0] ctrl_one_ff, ctrl_two_ff;
  logic [15:0] count_ff, cap1_ff, cap2_ff;
  logic [7:0] lo_copy_ff;
  logic frozen_ff;
  logic ovf_ff, cap1_flag_ff, cap2_flag_ff;
  logic ovf_armed_ff, cap1_armed_ff, cap2_armed_ff;
  logic cap1_block_ff, cap2_block_ff;
  logic ext_prev_ff, cap1_prev_ff, cap2_prev_ff;
  logic [2:0] pre_ff;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic ovf_irq_ff, cap_irq_ff;

  wire setup = PSEL && !PENABLE;
  wire acc = PSEL && PENABLE && CLK_EN; // [R23]
  wire [3:0] idx = PADDR[5:2];
  wire aligned = PADDR[1:0] == 2'h0 && PADDR[7:6] == 2'h0;
  wire rd = acc && !PWRITE;
  wire wr = acc && PWRITE;
  wire hit_cr1 = aligned && idx == IDX_CTRL_ONE;
  wire hit_cr2 = aligned && idx == IDX_CTRL_TWO;
  wire hit_sr = aligned && idx == IDX_STATUS;
  wire hit_chi = aligned && idx == IDX_COUNT_HI;
  wire hit_clo = aligned && idx == IDX_COUNT_LO;
  wire hit_ahi = aligned && idx == IDX_ALT_HI;
  wire hit_alo = aligned && idx == IDX_ALT_LO;
  wire hit_c1h = aligned && idx == IDX_CAP1_HI;
  wire hit_c1l = aligned && idx == IDX_CAP1_LO;
  wire hit_c2h = aligned && idx == IDX_CAP2_HI && CH2_PRESENT; // [R22]
  wire hit_c2l = aligned && idx == IDX_CAP2_LO && CH2_PRESENT; // [R22]
  wire mapped = hit_cr1 | hit_cr2 | hit_sr | hit_chi | hit_clo | hit_ahi | hit_alo
              | hit_c1h | hit_c1l | hit_c2h | hit_c2l;

  // ==========================================================
  // prescaler and external clock
  wire [1:0] clk_sel = ctrl_two_ff[CR2_CLK_HI:CR2_CLK_LO];
  wire ext_sel = clk_sel == CLK_EXT; // [R4]
  wire ext_in = EXT_BONDED ? EXT_CLOCK_PIN : 1'b1; // [R21]
  wire cap1_in = CAP1_BONDED ? CAPTURE_PIN_ONE : 1'b1; // [R21]
  wire cap2_in = CAP2_BONDED ? CAPTURE_PIN_TWO : 1'b1; // [R21]
  // edges detected on sampled pins; the partner keeps edges >= 4 cycles apart [R6]
  wire ext_edge = ctrl_two_ff[CR2_EXT_EDGE] ? (ext_in && !ext_prev_ff)
                                           : (!ext_in && ext_prev_ff); // [R5]
  wire [2:0] pre_mask = clk_sel == CLK_DIV2 ? 3'h1 : clk_sel == CLK_DIV4 ? 3'h3 : 3'h7;
  wire pre_wrap = (pre_ff & pre_mask) == pre_mask;
  // halt freezes the count; wait has no effect here
  wire run = !HALT; // [R13]
  wire tick = run && (ext_sel ? ext_edge : pre_wrap); // [R1] [R3]
  wire reload = wr && (hit_clo || hit_alo); // [R2]
  wire rollover = tick && !reload && count_ff == COUNT_TOP; // [R10]
  wire [15:0] nxt_count = reload ? COUNT_RESET : tick ? count_ff + 16'h0001 : count_ff;
  wire [2:0] nxt_pre = (run && !ext_sel) ? pre_ff + 3'h1 : pre_ff;

  // ==========================================================
  // capture
  wire pwm_opm = ctrl_two_ff[CR2_OPM] || ctrl_two_ff[CR2_PWM];
  wire cap1_edge = ctrl_one_ff[CR1_EDGE1] ? (cap1_in && !cap1_prev_ff)
                                         : (!cap1_in && cap1_prev_ff); // [R15] [R20]
  wire cap2_edge = ctrl_two_ff[CR2_EDGE2] ? (cap2_in && !cap2_prev_ff)
                                         : (!cap2_in && cap2_prev_ff); // [R15] [R20]
  wire cap1_take = cap1_edge && !cap1_block_ff && !pwm_opm; // [R14] [R18] [R19]
  wire cap2_take = cap2_edge && !cap2_block_ff && CH2_PRESENT; // [R14] [R18] [R22]
  wire rd_sr = rd && hit_sr;
  // a status read arms the clear of each flag that is set at that time
  wire ovf_clr = ovf_armed_ff && acc && hit_clo; // [R12] [R7]
  wire cap1_clr = cap1_armed_ff && acc && hit_c1l; // [R17]
  wire cap2_clr = cap2_armed_ff && acc && hit_c2l; // [R17]
  // set wins over clear
  wire nxt_ovf = rollover | (ovf_ff & ~ovf_clr);
  wire nxt_cap1_flag = cap1_take | (cap1_flag_ff & ~cap1_clr);
  wire nxt_cap2_flag = cap2_take | (cap2_flag_ff & ~cap2_clr);
  wire [7:0] status = {cap1_flag_ff, 1'b0, ovf_ff, cap2_flag_ff, 4'h0};

  // ==========================================================
  // read data
  wire hi_rd = rd && (hit_chi || hit_ahi); // [R8]
  wire lo_rd = rd && (hit_clo || hit_alo);
  wire [7:0] lo_view = frozen_ff ? lo_copy_ff : count_ff[7:0]; // [R8]
  wire [7:0] rbyte = hit_cr1 ? ctrl_one_ff : hit_cr2 ? ctrl_two_ff : hit_sr ? status :
    (hit_chi || hit_ahi) ? count_ff[15:8] : (hit_clo || hit_alo) ? lo_view :
    hit_c1h ? cap1_ff[15:8] : hit_c1l ? cap1_ff[7:0] :
    hit_c2h ? cap2_ff[15:8] : hit_c2l ? cap2_ff[7:0] : 8'h00;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      count_ff <= COUNT_RESET;
      pre_ff <= 3'h0;
      ctrl_one_ff <= CTRL_RESET;
      ctrl_two_ff <= CTRL_RESET;
      ext_prev_ff <= 1'b1;
      cap1_prev_ff <= 1'b1;
      cap2_prev_ff <= 1'b1;
    end else if (CLK_EN) begin
      count_ff <= nxt_count;
      pre_ff <= reload ? 3'h0 : nxt_pre;
      ext_prev_ff <= ext_in;
      cap1_prev_ff <= cap1_in;
      cap2_prev_ff <= cap2_in;
      if (wr && hit_cr1) begin
        ctrl_one_ff <= PWDATA[7:0];
      end
      if (wr && hit_cr2) begin
        ctrl_two_ff <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ovf_ff <= 1'b0;
      cap1_flag_ff <= 1'b0;
      cap2_flag_ff <= 1'b0;
      ovf_armed_ff <= 1'b0;
      cap1_armed_ff <= 1'b0;
      cap2_armed_ff <= 1'b0;
    end else if (CLK_EN) begin
      ovf_ff <= nxt_ovf; // [R10]
      cap1_flag_ff <= nxt_cap1_flag; // [R14]
      cap2_flag_ff <= nxt_cap2_flag;
      ovf_armed_ff <= rd_sr ? ovf_ff : (ovf_armed_ff && !ovf_clr);
      cap1_armed_ff <= rd_sr ? cap1_flag_ff : (cap1_armed_ff && !cap1_clr);
      cap2_armed_ff <= rd_sr ? cap2_flag_ff : (cap2_armed_ff && !cap2_clr);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cap1_ff <= 16'h0000;
      cap2_ff <= 16'h0000;
      cap1_block_ff <= 1'b0;
      cap2_block_ff <= 1'b0;
      frozen_ff <= 1'b0;
      lo_copy_ff <= 8'h00;
    end else if (CLK_EN) begin
      if (cap1_take) begin
        cap1_ff <= count_ff; // [R14]
      end
      if (cap2_take) begin
        cap2_ff <= count_ff;
      end
      if (rd && hit_c1h) begin
        cap1_block_ff <= 1'b1; // [R18]
      end else if (rd && hit_c1l) begin
        cap1_block_ff <= 1'b0;
      end
      if (rd && hit_c2h) begin
        cap2_block_ff <= 1'b1; // [R18]
      end else if (rd && hit_c2l) begin
        cap2_block_ff <= 1'b0;
      end
      if (hi_rd && !frozen_ff) begin
        frozen_ff <= 1'b1; // [R8] [R9]
        lo_copy_ff <= count_ff[7:0];
      end else if (lo_rd) begin
        frozen_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // bus answer and interrupt outputs
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      ovf_irq_ff <= 1'b0;
      cap_irq_ff <= 1'b0;
    end else if (CLK_EN) begin
      // answer is registered during setup, so access phase completes in one cycle
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= {24'h000000, rbyte};
      end
      ovf_irq_ff <= nxt_ovf && ctrl_one_ff[CR1_OVF_IE] && !CPU_IRQ_MASK; // [R11]
      cap_irq_ff <= (nxt_cap1_flag || nxt_cap2_flag)
                    && ctrl_one_ff[CR1_CAP_IE] && !CPU_IRQ_MASK; // [R16]
    end
  end

  // unmapped reads return zero without error
  assign PREADY = pready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = 1'b0;
  assign OVF_IRQ = ovf_irq_ff;
  assign CAP_IRQ = cap_irq_ff;

  wire unused_ok = mapped | ^PWDATA[31:8];

  // ==========================================================
  // checks
  a_reload_value: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R2]
    reload && CLK_EN |=> count_ff == COUNT_RESET) else $error("reload not FFFC");
  a_ovf_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R10]
    rollover && CLK_EN |=> ovf_ff) else $error("overflow flag not set");
  a_alt_no_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R7]
    ovf_ff && acc && hit_alo && !hit_clo |=> ovf_ff) else $error("alt read cleared flag");
  a_halt_stops: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R13]
    HALT && !reload |=> $stable(count_ff)) else $error("count moved in halt");
  a_cap_latch: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R14]
    cap2_take && CLK_EN |=> cap2_ff == $past(count_ff) && cap2_flag_ff)
    else $error("capture two not latched");
  a_cap_blocked: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R18]
    cap1_block_ff |=> $stable(cap1_ff)) else $error("capture during block");
  a_opm_no_cap1: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R19]
    pwm_opm |-> !cap1_take) else $error("channel one captured in pwm");
  a_irq_masked: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R11]
    CPU_IRQ_MASK && CLK_EN |=> !OVF_IRQ && !CAP_IRQ) else $error("irq while masked");
  a_ext_only: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R4]
    !ext_sel && !pre_wrap |-> !tick) else $error("tick without prescaler");
  a_freeze_lo: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R8]
    frozen_ff && !lo_rd && CLK_EN |=> frozen_ff && $stable(lo_copy_ff))
    else $error("low copy changed");
endmodule : timer16_capture

// ---- shared/timer16_pkg.sv ----
package timer16_pkg;
  // register indices (byte address = index * 4); word offsets chosen for this block
  localparam logic [3:0] IDX_CTRL_TWO = 4'h0;
  localparam logic [3:0] IDX_CTRL_ONE = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_CAP1_HI = 4'h4;
  localparam logic [3:0] IDX_CAP1_LO = 4'h5;
  localparam logic [3:0] IDX_COUNT_HI = 4'h8;
  localparam logic [3:0] IDX_COUNT_LO = 4'h9;
  localparam logic [3:0] IDX_ALT_HI = 4'hA;
  localparam logic [3:0] IDX_ALT_LO = 4'hB;
  localparam logic [3:0] IDX_CAP2_HI = 4'hC;
  localparam logic [3:0] IDX_CAP2_LO = 4'hD;
  // control one fields
  localparam int CR1_CAP_IE = 7;
  localparam int CR1_OVF_IE = 5;
  localparam int CR1_EDGE1 = 1;
  // control two fields
  localparam int CR2_OPM = 4;
  localparam int CR2_PWM = 3;
  localparam int CR2_CLK_HI = 3;
  localparam int CR2_CLK_LO = 2;
  localparam int CR2_EDGE2 = 1;
  localparam int CR2_EXT_EDGE = 0;
  // status fields
  localparam int SR_CAP1 = 7;
  localparam int SR_OVF = 5;
  localparam int SR_CAP2 = 4;
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam int EXT_MIN_GAP = 4;
endpackage : timer16_pkg

// ---- verification/timer16_counter_input_capture_bench.sv ----
`timescale 1ns/1ns
module timer16_counter_input_capture_bench;
  import timer16_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic halt = 1'b1;
  logic irq_mask = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_pin, cap_one, cap_two, ovf_irq, cap_irq;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'h0000_0020;
  logic [7:0] rd;
  always #5 sys_clk = ~sys_clk;
  timer16_capture u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(1'b1), .HALT(halt),
    .CPU_IRQ_MASK(irq_mask), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_CLOCK_PIN(ext_pin), .CAPTURE_PIN_ONE(cap_one), .CAPTURE_PIN_TWO(cap_two),
    .OVF_IRQ(ovf_irq), .CAP_IRQ(cap_irq));
  timer16_pins u_pins (.clk(sys_clk), .ext_pin(ext_pin), .cap_one(cap_one), .cap_two(cap_two));
  // ==========================================
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift
  function automatic logic [15:0] ext_expect(input int k);
    return COUNT_RESET + 16'(k);
  endfunction : ext_expect
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // timeout ceiling well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ==========================================
  // apb byte access; read data taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // pready is looked at once settled; the transfer ends at the next rising edge
    @(negedge sys_clk);
    while (pready !== 1'b1) @(negedge sys_clk);
    rd = prdata[7:0];
    @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [3:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd & mask, exp);
  endtask : rdc
  // ==========================================
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(IDX_CTRL_ONE, 8'hFF, CTRL_RESET);
    rdc(IDX_COUNT_HI, 8'hFF, COUNT_RESET[15:8]);
    rdc(IDX_COUNT_LO, 8'hFF, COUNT_RESET[7:0]);
    rdc(IDX_ALT_HI, 8'hFF, COUNT_RESET[15:8]);
    rdc(4'hF, 8'hFF, 8'h00);
    $display("test reset done");
    halt <= 1'b0;
    repeat (14) @(posedge sys_clk);
    halt <= 1'b1;
    apb(1'b1, IDX_CTRL_ONE, 8'h20);
    rdc(IDX_STATUS, 8'h20, 8'h20);
    repeat (3) @(posedge sys_clk);
    chk({7'h0, ovf_irq}, 8'h01);
    irq_mask <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({7'h0, ovf_irq}, 8'h00);
    irq_mask <= 1'b0;
    apb(1'b0, IDX_ALT_LO, 8'h00);
    rdc(IDX_STATUS, 8'h20, 8'h20);
    apb(1'b1, IDX_COUNT_LO, 8'h55);
    rdc(IDX_STATUS, 8'h20, 8'h00);
    rdc(IDX_COUNT_HI, 8'hFF, COUNT_RESET[15:8]);
    rdc(IDX_ALT_LO, 8'hFF, COUNT_RESET[7:0]);
    $display("test overflow done");
    apb(1'b1, IDX_CTRL_ONE, 8'h82);
    apb(1'b1, IDX_CTRL_TWO, 8'h02);
    u_pins.cap_pulse(1'b0);
    u_pins.cap_pulse(1'b1);
    rdc(IDX_STATUS, 8'h90, 8'h90);
    chk({7'h0, cap_irq}, 8'h01);
    rdc(IDX_CAP1_HI, 8'hFF, COUNT_RESET[15:8]);
    rdc(IDX_CAP1_LO, 8'hFF, COUNT_RESET[7:0]);
    rdc(IDX_CAP2_HI, 8'hFF, COUNT_RESET[15:8]);
    rdc(IDX_CAP2_LO, 8'hFF, COUNT_RESET[7:0]);
    rdc(IDX_STATUS, 8'h90, 8'h00);
    apb(1'b0, IDX_CAP1_HI, 8'h00);
    u_pins.cap_pulse(1'b0);
    rdc(IDX_STATUS, 8'h80, 8'h00);
    apb(1'b0, IDX_CAP1_LO, 8'h00);
    $display("test capture done");
    for (int t = 0; t < 4; t++) begin
      seed = xorshift(seed);
      n = int'(seed[2:0]) + 1;
      apb(1'b1, IDX_CTRL_TWO, 8'h0D);
      apb(1'b1, IDX_ALT_LO, seed[15:8]);
      halt <= 1'b0;
      u_pins.ext_pulses(n);
      repeat (3) @(posedge sys_clk);
      halt <= 1'b1;
      rdc(IDX_COUNT_HI, 8'hFF, 8'(ext_expect(n) >> 8));
      rdc(IDX_COUNT_LO, 8'hFF, 8'(ext_expect(n)));
    end
    $display("test external clock done");
    conclude();
  end
endmodule : timer16_counter_input_capture_bench

// ---- verification/timer16_pins.sv ----
`timescale 1ns/1ns
module timer16_pins (
  input wire logic clk,
  output logic ext_pin,
  output logic cap_one,
  output logic cap_two
);
  // pins idle high, the level the edge detectors hold in reset, so no false edge follows reset
  initial begin
    ext_pin = 1'b1;
    cap_one = 1'b1;
    cap_two = 1'b1;
  end
  // ==========================================
  // external clock: three cycles low, four high; one rising edge per pulse, seven cycles apart
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) ext_pin <= 1'b0;
      repeat (3) @(posedge clk);
      ext_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : ext_pulses
  // ==========================================
  // low pulse on a capture pin; the rising edge comes as it returns high
  task automatic cap_pulse(input logic two);
    @(posedge clk);
    if (two) cap_two <= 1'b0;
    else cap_one <= 1'b0;
    repeat (4) @(posedge clk);
    cap_two <= 1'b1;
    cap_one <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : cap_pulse
endmodule : timer16_pins
